/* hdl/smr_target.sv */
// Purpose: Two-wire target giving indexed block access to a byte register bank
// Assumes: Host drives the serial clock; pins are sampled by clk at 40 MHz
// Notes:   Register contents are exported as a flat vector for other logic
//
// Operation
// - Write address byte d2 selects this device for writing.
// - Device acknowledges address, index and count bytes.
// - Data bytes go to consecutive registers from the index, each acknowledged.
// - Read address d3 is acknowledged, then device drives data.
// - First byte read back is the contents of register 8.
// - Then ascending register bytes from the index, until the host does not acknowledge.
`timescale 1ns/1ps
module smr_target
    import smr_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  ce,
    // Link pins
    input  wire logic                  scl_i,
    input  wire logic                  sda_i,
    output logic                       sda_o,
    output logic                       sda_oe,
    // Register contents and busy flag
    output logic [SMR_NREGS*8-1:0]     regs_q,
    output logic                       busy_q
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RXB, ST_TXB, ST_TXACK} smr_state_t;
    typedef enum logic [1:0] {PH_INDEX, PH_COUNT, PH_DATA} smr_phase_t;

    smr_line_t  ln;
    logic       scl_p_q, sda_p_q;
    smr_state_t st_q, st_d;
    smr_phase_t ph_q, ph_d;
    logic [7:0] sh_q, sh_d;
    logic [3:0] bit_q, bit_d;
    logic [4:0] idx_q, idx_d;
    logic [7:0] cnt_q, cnt_d;
    logic       rd_q, rd_d;
    logic       first_q, first_d;
    logic       oe_q, oe_d;
    logic       ackd_q, ackd_d;
    smr_wr_t    wr;
    smr_line_t  pins;
    logic [7:0] bank [SMR_NREGS];

    assign pins = '{scl: scl_i, sda: sda_i};

    smr_sync u_sync
    (
        .clk  (clk),
        .rstn (rstn),
        .ce   (ce),
        .din  (pins),
        .dout (ln)
    );

    wire scl_rise = ln.scl && !scl_p_q;
    wire scl_fall = !ln.scl && scl_p_q;
    wire start_c  = ln.scl && scl_p_q && sda_p_q && !ln.sda;
    wire stop_c   = ln.scl && scl_p_q && !sda_p_q && ln.sda;
    wire [7:0] rxb = {sh_q[6:0], ln.sda};

    // ****************************************************
    // Protocol engine
    // ****************************************************
    always_comb
    begin
        st_d = st_q; ph_d = ph_q; sh_d = sh_q; bit_d = bit_q;
        idx_d = idx_q; cnt_d = cnt_q; rd_d = rd_q; first_d = first_q;
        oe_d = oe_q; ackd_d = ackd_q;
        wr = '{we: 1'b0, idx: idx_q, data: rxb};
        if (start_c)
        begin
            st_d = ST_ADDR; bit_d = 4'h0; oe_d = 1'b0;
        end
        else if (stop_c)
        begin
            st_d = ST_IDLE; oe_d = 1'b0;
        end
        else
        begin
            case (st_q)
                ST_ADDR, ST_RXB:
                begin
                    if (scl_rise)
                    begin
                        sh_d = rxb;
                        bit_d = bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'h8)
                    begin
                        ackd_d = 1'b1;
                        st_d = ST_ACK;
                        oe_d = 1'b1;
                        if (st_q == ST_ADDR)
                        begin
                            rd_d = sh_q[0];
                            first_d = 1'b1;
                            if (sh_q == SMR_ADDR_WR)
                                ph_d = PH_INDEX;
                            else if (sh_q == SMR_ADDR_RD)
                                cnt_d = bank[SMR_IDX_COUNT];
                            else
                            begin
                                st_d = ST_IDLE; oe_d = 1'b0;
                            end
                        end
                        else if (ph_q == PH_INDEX)
                        begin
                            idx_d = sh_q[SMR_IDX_W-1:0]; ph_d = PH_COUNT;
                        end
                        else if (ph_q == PH_COUNT)
                            ph_d = PH_DATA;
                        else
                        begin
                            wr = '{we: 1'b1, idx: idx_q, data: sh_q};
                            idx_d = idx_q + 5'h01;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        bit_d = 4'h0;
                        if (rd_q)
                        begin
                            st_d = ST_TXB; oe_d = 1'b1;
                            sh_d = cnt_q;
                            oe_d = !cnt_q[7];
                        end
                        else
                        begin
                            st_d = ST_RXB; oe_d = 1'b0;
                        end
                    end
                end
                ST_TXB:
                begin
                    if (scl_fall)
                    begin
                        bit_d = bit_q + 4'h1;
                        if (bit_q == 4'h7)
                        begin
                            st_d = ST_TXACK; oe_d = 1'b0;
                        end
                        else
                        begin
                            sh_d = {sh_q[6:0], 1'b0};
                            oe_d = !sh_q[6];
                        end
                    end
                end
                ST_TXACK:
                begin
                    if (scl_rise && ln.sda)
                        st_d = ST_IDLE;
                    else if (scl_fall)
                    begin
                        bit_d = 4'h0;
                        st_d = ST_TXB;
                        sh_d = first_q ? bank[idx_q] : bank[idx_q + 5'h01];
                        if (!first_q)
                            idx_d = idx_q + 5'h01;
                        first_d = 1'b0;
                        oe_d = first_q ? !bank[idx_q][7] : !bank[idx_q + 5'h01][7];
                    end
                end
                default:
                begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= ST_IDLE; ph_q <= PH_INDEX; sh_q <= 8'h00; bit_q <= 4'h0;
            idx_q <= 5'h00; cnt_q <= 8'h00; rd_q <= 1'b0; first_q <= 1'b0;
            oe_q <= 1'b0; ackd_q <= 1'b0; scl_p_q <= 1'b1; sda_p_q <= 1'b1;
        end
        else if (ce)
        begin
            st_q <= st_d; ph_q <= ph_d; sh_q <= sh_d; bit_q <= bit_d;
            idx_q <= idx_d; cnt_q <= cnt_d; rd_q <= rd_d; first_q <= first_d;
            oe_q <= oe_d; ackd_q <= ackd_d; scl_p_q <= ln.scl; sda_p_q <= ln.sda;
        end
    end

    // ****************************************************
    // Register bank
    // ****************************************************
    genvar gi;
    generate
        for (gi = 0; gi < SMR_NREGS; gi++)
        begin : g_reg
            logic [7:0] r_q, r_d;
            always_comb
            begin
                r_d = r_q;
                if (wr.we && wr.idx == SMR_IDX_W'(gi))
                    r_d = wr.data;
            end
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    r_q <= (gi == int'(SMR_IDX_COUNT)) ? SMR_COUNT_RST : SMR_REG_RST;
                else if (ce)
                    r_q <= r_d;
            end
            assign bank[gi] = r_q;
            assign regs_q[gi*8 +: 8] = r_q;
        end
    endgenerate

    // Outputs: data only ever pulled low
    assign sda_o  = 1'b0;
    assign sda_oe = oe_q;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            busy_q <= 1'b0;
        else if (ce)
            busy_q <= (st_d != ST_IDLE);
    end

    // ****************************************************
    // Checks
    // ****************************************************
    a_stop_idle: assert property (@(posedge clk) disable iff (!rstn)
        ce && stop_c |=> st_q == ST_IDLE && !oe_q) else $error("no idle after stop");
    a_ack_drive: assert property (@(posedge clk) disable iff (!rstn)
        ce && st_q != ST_ACK && st_d == ST_ACK |=> oe_q) else $error("ack not driven");
    a_wr_incr: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr.we |=> idx_q == $past(idx_q) + 5'h01) else $error("index not advanced");
    a_wr_store: assert property (@(posedge clk) disable iff (!rstn)
        ce && wr.we |=> bank[$past(wr.idx)] == $past(wr.data)) else $error("byte not stored");
    a_rd_count: assert property (@(posedge clk) disable iff (!rstn)
        ce && st_q == ST_ACK && rd_q && scl_fall |=> sh_q == $past(cnt_q)) else $error("count not first");
    a_cnt_load: assert property (@(posedge clk) disable iff (!rstn)
        ce && st_q == ST_ADDR && scl_fall && bit_q == 4'h8 && sh_q == SMR_ADDR_RD
        |=> cnt_q == $past(bank[SMR_IDX_COUNT])) else $error("count not from reg 8");
    a_addr_wr: assert property (@(posedge clk) disable iff (!rstn)
        ce && !start_c && !stop_c && st_q == ST_ADDR && scl_fall && bit_q == 4'h8
        && sh_q != SMR_ADDR_WR && sh_q != SMR_ADDR_RD |=> !oe_q) else $error("foreign ack");
    a_nack_idle: assert property (@(posedge clk) disable iff (!rstn)
        ce && !start_c && !stop_c && st_q == ST_TXACK && scl_rise && ln.sda
        |=> st_q == ST_IDLE) else $error("nack not honoured");
    c_write: cover property (@(posedge clk) disable iff (!rstn) wr.we);
    c_read: cover property (@(posedge clk) disable iff (!rstn) st_q == ST_TXB);
    c_nack: cover property (@(posedge clk) disable iff (!rstn) st_q == ST_TXACK && scl_rise && ln.sda);
endmodule

/* common/smr_pkg.sv */
// Purpose: Shared constants and types for the serial register access block
// Assumes: Byte-wide register bank reached over a two-wire management link
// Notes:   Link pins are sampled by the system clock
package smr_pkg;
    // ****************************************************
    // Link addressing
    // ****************************************************
    localparam logic [6:0] SMR_DEV_ADDR   = 7'h69;
    localparam logic [7:0] SMR_ADDR_WR    = 8'hd2;
    localparam logic [7:0] SMR_ADDR_RD    = 8'hd3;
    // ****************************************************
    // Register bank
    // ****************************************************
    localparam int         SMR_NREGS      = 32;
    localparam int         SMR_IDX_W      = 5;
    localparam logic [4:0] SMR_IDX_COUNT  = 5'h08;
    localparam logic [7:0] SMR_COUNT_RST  = 8'h09;
    localparam logic [7:0] SMR_REG_RST    = 8'h00;
    localparam int         SMR_SYNC_W     = 2;

    typedef struct packed {
        logic scl;
        logic sda;
    } smr_line_t;

    typedef struct packed {
        logic       we;
        logic [4:0] idx;
        logic [7:0] data;
    } smr_wr_t;
endpackage

/* hdl/smr_sync.sv */
// Purpose: Two-flop synchroniser for the link lines
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
module smr_sync
    import smr_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rstn,
    input  wire logic      ce,
    // Lines
    input  wire smr_line_t din,
    output smr_line_t      dout
);
    smr_line_t s1_q;
    smr_line_t s2_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_q <= '{scl: 1'b1, sda: 1'b1};
            s2_q <= '{scl: 1'b1, sda: 1'b1};
        end
        else if (ce)
        begin
            s1_q <= din;
            s2_q <= s1_q;
        end
    end

    assign dout = s2_q;
endmodule

/* testbench/smr_host.sv */
// Purpose: Behavioural host for the two-wire link
// Assumes: Data line has a pull-up; host only pulls it low
// Notes:   Each clock phase lasts 8 system clocks
`timescale 1ns/1ps
module smr_host
    import smr_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Link
    input  wire logic sda,
    output logic      scl,
    output logic      sda_low
);
    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end
    task automatic drive(input logic c, input logic d, input int n);
        @(posedge clk);
        scl     <= c;
        sda_low <= ~d;
        repeat (n - 1) @(posedge clk);
    endtask
    task automatic start();
        drive(1'b1, 1'b1, 8);
        drive(1'b1, 1'b0, 8);
        drive(1'b0, 1'b0, 8);
    endtask
    task automatic rstart();
        drive(1'b0, 1'b1, 4);
        drive(1'b1, 1'b1, 8);
        drive(1'b1, 1'b0, 8);
        drive(1'b0, 1'b0, 4);
    endtask
    task automatic stop();
        drive(1'b0, 1'b0, 4);
        drive(1'b1, 1'b0, 8);
        drive(1'b1, 1'b1, 8);
    endtask
    task automatic bitx(input logic b, output logic r);
        drive(1'b0, b, 4);
        drive(1'b1, b, 4);
        r = sda;
        repeat (4) @(posedge clk);
        drive(1'b0, b, 4);
    endtask
    // Sends d MSB first, then drives ack slot with last (0 = ack)
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(last, r);
        ack = ~r;
    endtask
endmodule

/* testbench/smr_target_tb.sv */
// Purpose: Self-checking bench for the serial register access target
// Assumes: Host model drives the link; pull-up on the data line
// Notes:   Expected bank contents kept in a local model
`timescale 1ns/1ps
module smr_target_tb
    import smr_pkg::*;
();
    logic                   clk;
    logic                   rstn;
    logic                   ce;
    logic                   scl;
    logic                   host_low;
    logic                   sda_o;
    logic                   sda_oe;
    logic [SMR_NREGS*8-1:0] regs_q;
    logic                   busy_q;
    wire                    sda_w;
    logic [7:0]             mdl [32];
    int                     n_errors;
    int                     samples_checked;

    assign sda_w = ~host_low & (sda_oe ? sda_o : 1'b1);

    smr_target dut (.clk(clk), .rstn(rstn), .ce(ce), .scl_i(scl), .sda_i(sda_w),
                    .sda_o(sda_o), .sda_oe(sda_oe), .regs_q(regs_q), .busy_q(busy_q));
    smr_host host (.clk(clk), .sda(sda_w), .scl(scl), .sda_low(host_low));

    // ****************************************************
    // Checking
    // ****************************************************
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic idle_chk();
        chk("sda_oe", 8'h00, {7'h0, sda_oe});
        chk("busy", 8'h00, {7'h0, busy_q});
    endtask
    // ****************************************************
    // Scenarios
    // ****************************************************
    task automatic t_reset();
        for (int k = 0; k < 32; k++)
            chk("reg", mdl[k], regs_q[8*k +: 8]);
        idle_chk();
    endtask
    task automatic hdr(input logic [7:0] idx);
        logic [7:0] q;
        logic       a;
        host.start();
        host.xfer(SMR_ADDR_WR, 1'b1, q, a);
        chk("ack_addr", 8'h01, {7'h0, a});
        host.xfer(idx, 1'b1, q, a);
        chk("ack_idx", 8'h01, {7'h0, a});
        chk("busy", 8'h01, {7'h0, busy_q});
    endtask
    task automatic t_write(input logic [7:0] idx, input logic [7:0] d [$]);
        logic [7:0] q;
        logic       a;
        hdr(idx);
        host.xfer(8'(d.size()), 1'b1, q, a);
        chk("ack_cnt", 8'h01, {7'h0, a});
        foreach (d[i])
        begin
            host.xfer(d[i], 1'b1, q, a);
            chk("ack_data", 8'h01, {7'h0, a});
            mdl[(idx + i) % 32] = d[i];
        end
        host.stop();
        for (int k = 0; k < 32; k++)
            chk("reg", mdl[k], regs_q[8*k +: 8]);
        idle_chk();
    endtask
    task automatic t_read(input logic [7:0] idx, input int n);
        logic [7:0] q;
        logic       a;
        hdr(idx);
        host.rstart();
        host.xfer(SMR_ADDR_RD, 1'b1, q, a);
        chk("ack_rd", 8'h01, {7'h0, a});
        host.xfer(8'hff, 1'b0, q, a);
        chk("count", mdl[8], q);
        for (int i = 0; i < n; i++)
        begin
            host.xfer(8'hff, i == n - 1, q, a);
            chk("rdata", mdl[(idx + i) % 32], q);
        end
        host.stop();
        idle_chk();
    endtask
    task automatic t_refuse();
        logic [7:0] q;
        logic       a;
        host.start();
        host.xfer(8'hd4, 1'b1, q, a);
        chk("ack_bad", 8'h00, {7'h0, a});
        host.xfer(8'h00, 1'b1, q, a);
        chk("ack_after", 8'h00, {7'h0, a});
        host.stop();
        idle_chk();
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        summarize();
    end
    initial
    begin
        rstn            = 1'b0;
        ce              = 1'b1;
        n_errors        = 0;
        samples_checked = 0;
        for (int k = 0; k < 32; k++)
            mdl[k] = (k == 8) ? SMR_COUNT_RST : SMR_REG_RST;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_write(8'h1e, '{8'ha1, 8'hb2, 8'hc3});
        t_read(8'h1e, 3);
        t_write(8'h08, '{8'h02});
        t_read(8'h07, 2);
        t_refuse();
        summarize();
    end
endmodule
